/* pkg/ciex_regs.vh */
// constants for the instruction subset execution block
// assumes inclusion by bare name from hdl files
`ifndef CIEX_REGS_VH
`define CIEX_REGS_VH

// ----------------------------------------------------------------
// operation select codes
// ----------------------------------------------------------------
`define CIEX_OP_ROTATE_RIGHT   3'h0
`define CIEX_OP_SLEEP          3'h1
`define CIEX_OP_LIT_MINUS_ACC  3'h2
`define CIEX_OP_REG_MINUS_ACC  3'h3
`define CIEX_OP_REG_MINUS_BORR 3'h4
`define CIEX_OP_NIBBLE_EXCH    3'h5
`define CIEX_OP_DIRECTION_LOAD 3'h6
`define CIEX_OP_XOR_LITERAL    3'h7

// ----------------------------------------------------------------
// direction register selectors
// ----------------------------------------------------------------
`define CIEX_DIR_SEL_PORT_A    7'h05
`define CIEX_DIR_SEL_PORT_B    7'h06
`define CIEX_DIR_SEL_PORT_C    7'h07

// ----------------------------------------------------------------
// destination bit values
// ----------------------------------------------------------------
`define CIEX_DEST_ACC          1'b0
`define CIEX_DEST_REG          1'b1

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define CIEX_RST_ACC           8'h00
`define CIEX_RST_DIRECTION     8'hff
`define CIEX_RST_TIMEOUT       1'b1
`define CIEX_RST_POWER_DOWN    1'b1
`define CIEX_RST_WATCHDOG      8'h00

`endif

/* hdl/ciex_alu.v */
// combinational result and flag logic for the instruction subset
// assumes operands are stable for the cycle in which they are used
`timescale 1ns/1ns
`include "ciex_regs.vh"

module ciex_alu (
  // operation and operands
  input  wire [2:0] op_in,
  input  wire [7:0] acc_in,
  input  wire [7:0] operand_in,
  input  wire       carry_in,
  // result and flags
  output reg  [7:0] result_out,
  output reg        carry_out,
  output reg        digit_carry_out,
  output wire       zero_out,
  output reg        upd_carry_out,
  output reg        upd_digit_out,
  output reg        upd_zero_out
);

  // ----------------------------------------------------------------
  // subtraction core
  // ----------------------------------------------------------------
  reg       sub_cin;
  reg [8:0] sub_full;
  reg [4:0] sub_low;

  // operand + ~acc + cin; a clear carry acts as a borrow
  always @*
  begin
    sub_cin  = (op_in == `CIEX_OP_REG_MINUS_BORR) ? carry_in : 1'b1; // RQ6
    sub_full = {1'b0, operand_in} + {1'b0, ~acc_in} + {8'h00, sub_cin};
    sub_low  = {1'b0, operand_in[3:0]} + {1'b0, ~acc_in[3:0]}
             + {4'h0, sub_cin};
  end

  // zero flag follows the 8-bit result
  assign zero_out = (result_out == 8'h00); // RQ10

  // ----------------------------------------------------------------
  // result and flag select
  // ----------------------------------------------------------------
  always @*
  begin
    result_out      = operand_in;
    carry_out       = carry_in;
    digit_carry_out = 1'b0;
    upd_carry_out   = 1'b0;
    upd_digit_out   = 1'b0;
    upd_zero_out    = 1'b0;
    case (op_in)
      `CIEX_OP_ROTATE_RIGHT:
      begin
        result_out    = {carry_in, operand_in[7:1]}; // RQ1
        carry_out     = operand_in[0]; // RQ1
        upd_carry_out = 1'b1;
      end
      `CIEX_OP_LIT_MINUS_ACC, `CIEX_OP_REG_MINUS_ACC,
      `CIEX_OP_REG_MINUS_BORR:
      begin
        // carry out set means no borrow: acc not above operand
        result_out      = sub_full[7:0]; // RQ4 RQ5 RQ6
        carry_out       = sub_full[8]; // RQ4 RQ5
        digit_carry_out = sub_low[4]; // RQ4 RQ5
        upd_carry_out   = 1'b1;
        upd_digit_out   = 1'b1;
        upd_zero_out    = 1'b1; // RQ6
      end
      `CIEX_OP_NIBBLE_EXCH:
        result_out = {operand_in[3:0], operand_in[7:4]}; // RQ7
      `CIEX_OP_XOR_LITERAL:
      begin
        result_out   = acc_in ^ operand_in; // RQ9
        upd_zero_out = 1'b1; // RQ9
      end
      default:
        result_out = acc_in;
    endcase
  end

endmodule // ciex_alu

/* hdl/ciex_exec.v */
// execution unit for one part of an 8-bit core's instruction set
// assumes the core's decoder drives the request ports on clk_in and
// supplies the addressed register's value in the same cycle
//
// Operation
// RQ1 - rotate right through carry, only carry changes
// RQ2 - destination bit picks accumulator or register
// RQ3 - sleep clears watchdog, sets timeout, clears powerdown
// RQ4 - literal minus accumulator, carry and digit carry
// RQ5 - register minus accumulator, carry and digit carry
// RQ6 - subtract with borrow, updates carry, digit, zero
// RQ7 - swap nibbles into destination, flags unchanged
// RQ8 - accumulator loads port direction register five-seven
// RQ9 - xor literal into accumulator, zero only
// RQ10 - zero set when result equals zero
`timescale 1ns/1ns
`include "ciex_regs.vh"

module ciex_exec #(
  parameter PRESCALE_W = 4,
  parameter WATCHDOG_W = 8
) (
  // clock and reset
  input  wire                  clk_in,
  input  wire                  rst_in,
  // instruction request from the decoder
  input  wire                  op_valid_in,
  input  wire [2:0]            op_code_in,
  input  wire [6:0]            reg_addr_in,
  input  wire                  dest_in,
  input  wire [7:0]            literal_in,
  input  wire [7:0]            reg_data_in,
  // wake event from outside the clock domain
  input  wire                  wake_in,
  // accumulator and status flags
  output reg  [7:0]            acc_out,
  output reg                   carry_out,
  output reg                   digit_carry_flag_out,
  output reg                   zero_out,
  output reg                   timeout_flag_out,
  output reg                   power_down_flag_out,
  // register file write-back
  output reg                   reg_wr_out,
  output reg  [6:0]            reg_wr_addr_out,
  output reg  [7:0]            reg_wr_data_out,
  // port direction registers
  output reg  [7:0]            port_a_direction_out,
  output reg  [7:0]            port_b_direction_out,
  output reg  [7:0]            port_c_direction_out,
  // watchdog and power state
  output reg  [WATCHDOG_W-1:0] watchdog_counter_out,
  output reg                   watchdog_tick_out,
  output reg                   sleep_mode_out
);

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  // literal operations take the literal in place of the register
  function is_literal_op;
    input [2:0] op;
    begin
      is_literal_op = (op == `CIEX_OP_LIT_MINUS_ACC) ||
                      (op == `CIEX_OP_XOR_LITERAL);
    end
  endfunction

  // operations whose result is steered by the destination bit
  function has_dest_bit;
    input [2:0] op;
    begin
      has_dest_bit = (op == `CIEX_OP_ROTATE_RIGHT)  ||
                     (op == `CIEX_OP_REG_MINUS_ACC) ||
                     (op == `CIEX_OP_REG_MINUS_BORR) ||
                     (op == `CIEX_OP_NIBBLE_EXCH);
    end
  endfunction

  // ----------------------------------------------------------------
  // alu
  // ----------------------------------------------------------------
  wire [7:0] alu_operand;
  wire [7:0] alu_result;
  wire       alu_carry;
  wire       alu_digit;
  wire       alu_zero;
  wire       alu_upd_c;
  wire       alu_upd_dc;
  wire       alu_upd_z;

  assign alu_operand = is_literal_op(op_code_in) ? literal_in
                                                 : reg_data_in;

  ciex_alu u_alu (
    .op_in           (op_code_in),
    .acc_in          (acc_out),
    .operand_in      (alu_operand),
    .carry_in        (carry_out),
    .result_out      (alu_result),
    .carry_out       (alu_carry),
    .digit_carry_out (alu_digit),
    .zero_out        (alu_zero),
    .upd_carry_out   (alu_upd_c),
    .upd_digit_out   (alu_upd_dc),
    .upd_zero_out    (alu_upd_z)
  );

  // ----------------------------------------------------------------
  // request qualification
  // ----------------------------------------------------------------
  wire exec_ok;
  wire do_sleep;
  wire do_dir;
  wire to_reg;
  wire to_acc;

  // requests are ignored while asleep; the core is halted then
  assign exec_ok  = op_valid_in && !sleep_mode_out;
  assign do_sleep = exec_ok && (op_code_in == `CIEX_OP_SLEEP);
  assign do_dir   = exec_ok && (op_code_in == `CIEX_OP_DIRECTION_LOAD);
  assign to_reg   = exec_ok && has_dest_bit(op_code_in) &&
                    (dest_in == `CIEX_DEST_REG); // RQ2
  assign to_acc   = exec_ok && !do_sleep && !do_dir &&
                    (is_literal_op(op_code_in) ||
                     (dest_in == `CIEX_DEST_ACC)); // RQ2

  // ----------------------------------------------------------------
  // accumulator and arithmetic flags
  // ----------------------------------------------------------------
  always @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      acc_out              <= `CIEX_RST_ACC;
      carry_out            <= 1'b0;
      digit_carry_flag_out <= 1'b0;
      zero_out             <= 1'b0;
    end
    else if (exec_ok)
    begin
      if (to_acc)
        acc_out <= alu_result; // RQ2 RQ4 RQ9
      if (alu_upd_c)
        carry_out <= alu_carry; // RQ1 RQ4 RQ5 RQ6
      if (alu_upd_dc)
        digit_carry_flag_out <= alu_digit; // RQ4 RQ5 RQ6
      if (alu_upd_z)
        zero_out <= alu_zero; // RQ10
    end
  end

  // ----------------------------------------------------------------
  // register file write-back, one-cycle strobe
  // ----------------------------------------------------------------
  always @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      reg_wr_out      <= 1'b0;
      reg_wr_addr_out <= 7'h00;
      reg_wr_data_out <= 8'h00;
    end
    else
    begin
      reg_wr_out <= to_reg; // RQ2
      if (to_reg)
      begin
        reg_wr_addr_out <= reg_addr_in;
        reg_wr_data_out <= alu_result; // RQ1 RQ5 RQ7
      end
    end
  end

  // ----------------------------------------------------------------
  // port direction registers
  // ----------------------------------------------------------------
  // selectors outside five to seven load nothing
  always @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      port_a_direction_out <= `CIEX_RST_DIRECTION;
      port_b_direction_out <= `CIEX_RST_DIRECTION;
      port_c_direction_out <= `CIEX_RST_DIRECTION;
    end
    else if (do_dir)
    begin
      case (reg_addr_in)
        `CIEX_DIR_SEL_PORT_A: port_a_direction_out <= acc_out; // RQ8
        `CIEX_DIR_SEL_PORT_B: port_b_direction_out <= acc_out; // RQ8
        `CIEX_DIR_SEL_PORT_C: port_c_direction_out <= acc_out; // RQ8
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // wake synchroniser
  // ----------------------------------------------------------------
  reg wake_meta_r;
  reg wake_sync_r;

  always @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      wake_meta_r <= 1'b0;
      wake_sync_r <= 1'b0;
    end
    else
    begin
      wake_meta_r <= wake_in;
      wake_sync_r <= wake_meta_r;
    end
  end

  // ----------------------------------------------------------------
  // power state and status flags
  // ----------------------------------------------------------------
  // entering sleep wins over a wake level seen in the same cycle
  always @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      sleep_mode_out      <= 1'b0;
      timeout_flag_out    <= `CIEX_RST_TIMEOUT;
      power_down_flag_out <= `CIEX_RST_POWER_DOWN;
    end
    else if (do_sleep)
    begin
      sleep_mode_out      <= 1'b1;
      timeout_flag_out    <= 1'b1; // RQ3
      power_down_flag_out <= 1'b0; // RQ3
    end
    else if (wake_sync_r)
      sleep_mode_out <= 1'b0;
  end

  // ----------------------------------------------------------------
  // watchdog prescaler and counter
  // ----------------------------------------------------------------
  // the prescaler is a divider; its wrap is a one-cycle enable
  reg [PRESCALE_W-1:0] prescale_r;
  wire                 prescale_wrap;

  assign prescale_wrap = (prescale_r == {PRESCALE_W{1'b1}});

  always @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      prescale_r           <= {PRESCALE_W{1'b0}};
      watchdog_counter_out <= {WATCHDOG_W{1'b0}};
      watchdog_tick_out    <= 1'b0;
    end
    else if (do_sleep)
    begin
      prescale_r           <= {PRESCALE_W{1'b0}}; // RQ3
      watchdog_counter_out <= {WATCHDOG_W{1'b0}}; // RQ3
      watchdog_tick_out    <= 1'b0;
    end
    else
    begin
      prescale_r        <= prescale_r + {{(PRESCALE_W-1){1'b0}}, 1'b1};
      watchdog_tick_out <= prescale_wrap;
      if (prescale_wrap)
        watchdog_counter_out <= watchdog_counter_out +
                                {{(WATCHDOG_W-1){1'b0}}, 1'b1};
    end
  end

endmodule // ciex_exec

/* verification/ciex_exec_properties.sv */
// concurrent checks for the instruction subset execution unit
// assumes it is bound to ciex_exec and sees its ports only
`timescale 1ns/1ns

module ciex_exec_properties #(
  parameter WATCHDOG_W = 8
) (
  // clock, reset and request
  input wire                  clk_in,
  input wire                  rst_in,
  input wire                  op_valid_in,
  input wire [2:0]            op_code_in,
  input wire [6:0]            reg_addr_in,
  input wire                  dest_in,
  input wire [7:0]            literal_in,
  input wire [7:0]            reg_data_in,
  // results
  input wire [7:0]            acc_out,
  input wire                  carry_out,
  input wire                  digit_carry_flag_out,
  input wire                  zero_out,
  input wire                  timeout_flag_out,
  input wire                  power_down_flag_out,
  input wire                  reg_wr_out,
  input wire [7:0]            port_a_direction_out,
  input wire [WATCHDOG_W-1:0] watchdog_counter_out,
  input wire                  sleep_mode_out
);
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // a request asleep is dropped, so only awake ones count
  wire       tk = op_valid_in && !sleep_mode_out;
  wire [2:0] oc = op_code_in;

  AST_ROT: assert property (
    tk && oc == 3'h0 |=> carry_out == $past(reg_data_in[0])
    && $stable(zero_out)) else $error("rotate carry wrong");
  AST_DST: assert property (
    tk && dest_in && (oc == 3'h0 || oc == 3'h3 || oc == 3'h4 || oc == 3'h5)
    |=> reg_wr_out && $stable(acc_out)) else $error("dest reg wrong");
  AST_SLP: assert property (
    tk && oc == 3'h1 |=> timeout_flag_out && !power_down_flag_out
    && watchdog_counter_out == '0) else $error("sleep entry wrong");
  AST_LIT: assert property (
    tk && oc == 3'h2 |=> carry_out == ($past(acc_out) <= $past(literal_in)))
    else $error("literal subtract carry wrong");
  AST_SUB: assert property (
    tk && oc == 3'h3 |=> digit_carry_flag_out ==
    ($past(acc_out[3:0]) <= $past(reg_data_in[3:0])))
    else $error("subtract digit carry wrong");
  AST_BRW: assert property (
    tk && oc == 3'h4 && !dest_in |=> acc_out == $past(reg_data_in)
    - $past(acc_out) - !$past(carry_out)) else $error("borrow wrong");
  AST_SWP: assert property (
    tk && oc == 3'h5 |=> $stable(carry_out) && $stable(zero_out)
    && $stable(digit_carry_flag_out)) else $error("swap touched flags");
  AST_DIR: assert property (
    tk && oc == 3'h6 && reg_addr_in == 7'h05
    |=> port_a_direction_out == $past(acc_out)) else $error("dir load wrong");
  AST_XOR: assert property (
    tk && oc == 3'h7 |=> acc_out == ($past(acc_out) ^ $past(literal_in))
    && zero_out == (acc_out == 8'h00)) else $error("xor wrong");

  // main scenarios reached
  cover property (tk && oc == 3'h1);
  cover property (reg_wr_out);
  cover property (tk && oc == 3'h6);
endmodule // ciex_exec_properties

bind ciex_exec ciex_exec_properties #(.WATCHDOG_W(WATCHDOG_W))
  i_ciex_exec_properties (.clk_in(clk_in), .rst_in(rst_in),
  .op_valid_in(op_valid_in), .op_code_in(op_code_in),
  .reg_addr_in(reg_addr_in), .dest_in(dest_in), .literal_in(literal_in),
  .reg_data_in(reg_data_in), .acc_out(acc_out), .carry_out(carry_out),
  .digit_carry_flag_out(digit_carry_flag_out), .zero_out(zero_out),
  .timeout_flag_out(timeout_flag_out),
  .power_down_flag_out(power_down_flag_out), .reg_wr_out(reg_wr_out),
  .port_a_direction_out(port_a_direction_out),
  .watchdog_counter_out(watchdog_counter_out),
  .sleep_mode_out(sleep_mode_out));

/* verification/ciex_exec_test.sv */
// directed testbench for the instruction subset execution unit
// assumes a lone ciex_exec driven as its decoder would drive it
`timescale 1ns/1ns

module ciex_exec_test;
  // ------------------------------------------------------------
  // signals and instance
  // ------------------------------------------------------------
  reg        clk_in = 1'b0;
  reg        rst_in = 1'b1;
  reg        vld    = 1'b0;
  reg  [2:0] opc    = 3'h0;
  reg  [6:0] adr    = 7'h00;
  reg        dst    = 1'b0;
  reg  [7:0] lit    = 8'h00;
  reg  [7:0] rdat   = 8'h00;
  reg        wake   = 1'b0;
  wire [7:0] acc, wdat, dir_a, dir_b, dir_c, wdog;
  wire [6:0] wadr;
  wire       c, dc, z, tmo, pdn, wr, slp, tck;
  integer    failures = 0;
  integer    checks_done = 0;
  integer    cycles = 0;
  integer    i;

  always #4 clk_in = ~clk_in;

  ciex_exec #(.PRESCALE_W(4), .WATCHDOG_W(8)) i_ciex_exec (
    .clk_in(clk_in), .rst_in(rst_in), .op_valid_in(vld),
    .op_code_in(opc), .reg_addr_in(adr), .dest_in(dst),
    .literal_in(lit), .reg_data_in(rdat), .wake_in(wake),
    .acc_out(acc), .carry_out(c), .digit_carry_flag_out(dc),
    .zero_out(z), .timeout_flag_out(tmo), .power_down_flag_out(pdn),
    .reg_wr_out(wr), .reg_wr_addr_out(wadr), .reg_wr_data_out(wdat),
    .port_a_direction_out(dir_a), .port_b_direction_out(dir_b),
    .port_c_direction_out(dir_c), .watchdog_counter_out(wdog),
    .watchdog_tick_out(tck), .sleep_mode_out(slp));

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task check(input [7:0] seen, input [7:0] exp, input string name);
    checks_done = checks_done + 1;
    if (seen !== exp)
    begin
      failures = failures + 1;
      $display("[FAIL] %0s expected %h seen %h", name, exp, seen);
    end
  endtask

  task flg(input ec, input edc, input ez);
    check(c, ec, "carry");
    check(dc, edc, "digit carry");
    check(z, ez, "zero");
  endtask

  // one request, held for exactly the taking edge
  task run(input [2:0] o, input [6:0] a, input d, input [7:0] k,
           input [7:0] f);
    @(posedge clk_in);
    vld  <= 1'b1;
    opc  <= o;
    adr  <= a;
    dst  <= d;
    lit  <= k;
    rdat <= f;
    @(posedge clk_in);
    vld  <= 1'b0;
    #1;
  endtask

  task give_verdict;
    if (failures == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // hang guard, far above the 66 cycles needed
  always @(posedge clk_in)
  begin
    cycles = cycles + 1;
    if (cycles == 2000)
    begin
      failures = failures + 1;
      give_verdict;
    end
  end

  // ------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------
  initial
  begin
    repeat (10) @(posedge clk_in);
    rst_in <= 1'b0;
    #1;
    check(acc, 8'h00, "acc");
    check(dir_a, 8'hff, "dir a");
    run(3'h7, 7'h00, 1'b0, 8'h3c, 8'h00);
    check(acc, 8'h3c, "xor acc");
    flg(1'b0, 1'b0, 1'b0);
    run(3'h7, 7'h00, 1'b0, 8'h3c, 8'h00);
    flg(1'b0, 1'b0, 1'b1);
    run(3'h7, 7'h00, 1'b0, 8'h15, 8'h00);
    run(3'h2, 7'h00, 1'b0, 8'h14, 8'h00);
    check(acc, 8'hff, "lit sub acc");
    flg(1'b0, 1'b0, 1'b0);
    run(3'h2, 7'h00, 1'b0, 8'hff, 8'h00);
    flg(1'b1, 1'b1, 1'b1);
    run(3'h0, 7'h12, 1'b1, 8'h00, 8'h80);
    check(wr, 1'b1, "rot wr");
    check(wadr, 8'h12, "rot addr");
    check(wdat, 8'hc0, "rot data");
    flg(1'b0, 1'b1, 1'b1);
    run(3'h0, 7'h12, 1'b0, 8'h00, 8'h03);
    check(wr, 1'b0, "rot wr");
    check(acc, 8'h01, "rot acc");
    run(3'h5, 7'h33, 1'b1, 8'h00, 8'h3c);
    check(wdat, 8'hc3, "swap data");
    check(acc, 8'h01, "swap acc");
    flg(1'b1, 1'b1, 1'b1);
    run(3'h3, 7'h21, 1'b1, 8'h00, 8'h10);
    check(wdat, 8'h0f, "sub data");
    flg(1'b1, 1'b0, 1'b0);
    run(3'h4, 7'h00, 1'b0, 8'h00, 8'h00);
    check(acc, 8'hff, "borrow acc");
    run(3'h4, 7'h00, 1'b0, 8'h00, 8'hff);
    check(acc, 8'hff, "borrow acc");
    flg(1'b0, 1'b0, 1'b0);
    run(3'h4, 7'h22, 1'b1, 8'h00, 8'h05);
    check(wdat, 8'h05, "borrow data");
    check(acc, 8'hff, "borrow keeps acc");
    for (i = 5; i < 8; i = i + 1)
    begin
      run(3'h7, 7'h00, 1'b0, i[7:0], 8'h00);
      run(3'h6, i[6:0], 1'b0, 8'h00, 8'h00);
    end
    run(3'h6, 7'h04, 1'b0, 8'h00, 8'h00);
    check(dir_a, 8'hfa, "dir a");
    check(dir_b, 8'hfc, "dir b");
    check(dir_c, 8'hfb, "dir c");
    run(3'h1, 7'h00, 1'b0, 8'h00, 8'h00);
    check(slp, 1'b1, "sleep");
    check(tmo, 1'b1, "timeout");
    check(pdn, 1'b0, "power down");
    check(wdog, 8'h00, "watchdog");
    run(3'h7, 7'h00, 1'b0, 8'hff, 8'h00);
    check(acc, 8'hfb, "asleep acc");
    // wake raised on an edge; sleep cleared the prescaler, so the
    // first tick lands sixteen cycles after the sleep edge
    @(posedge clk_in);
    wake <= 1'b1;
    repeat (4) @(posedge clk_in);
    wake <= 1'b0;
    #1;
    check(slp, 1'b0, "wake");
    repeat (9) @(posedge clk_in);
    #1;
    check(tck, 1'b1, "watchdog tick");
    check(wdog, 8'h01, "watchdog count");
    give_verdict;
  end
endmodule // ciex_exec_test
